// file: pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  // clock
  input wire logic clk,
  // pin
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic     pin_i
);
  logic lvl_q = 1'b0;
  // the device wins the wire while it drives
  assign pin_i = pin_oe ? pin_o : lvl_q;
  // every level holds 3 clocks or more, so the source stays below clk/4
  task automatic drive(input logic v, input int n);
    @(posedge clk);
    lvl_q <= v;
    repeat (n < 3 ? 3 : n) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: timer_chan.sv
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "timer_chan_defs.svh"

// Contract
// - enable clears counter, first tick loads load_value (code never loads in capture mode, counts up from zero)
// - overflow sets flag, optional irq, write-one clears
// - toggle mode drives pin, starts at polarity
// - toggle match inverts pin, sets compare flag
// - after match reload if reload_on_match set
// - event mode pin input, pin or prescaler clock
// - external clock synchronised, below quarter clk rate
// - polarity selects counted edge in event mode
// - event count match sets compare flag
// - measurement counts may vary by one
// - width mode start edge loads load_value
// - width mode end edge stops, captures count (code stops only with reload_on_match set, else free counts in MS_HALT)
// - width mode restart on next start edge
// - period mode measures same-polarity edges
// - period first edge loads, next captures
// - period mode reloads each period or overflows
// - capture mode first edge halts, captures count
// - polarity selects capture ending edge
module timer_chan
  import timer_chan_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // prescaler tick from the shared unit
  input  wire logic        prescale_tick,
  // timer pin
  input  wire logic        timer_io_pin_i,
  output logic             timer_io_pin_o,
  output logic             timer_io_pin_oe,
  // interrupts toward the core
  output logic             compare_irq,
  output logic             overflow_irq
);
  import timer_chan_pkg::*;

  localparam int W = 24;

  // =====================================================
  // bus slave
  logic [7:0]  addr_q;
  logic        wr_q;
  logic        rd_q;
  logic [W-1:0] ctrl_q, ctrl_d;
  logic [W-1:0] load_q;
  logic [W-1:0] cmp_q;
  logic [W-1:0] cap_q, cap_d;
  logic [W-1:0] cnt_q, cnt_d;
  logic        ovf_q, ovf_d;
  logic        cf_q, cf_d;
  logic        pin_q, pin_d;
  logic        en_q;
  logic        first_q, first_d;
  meas_t       ms_q, ms_d;
  logic        s1_q, s2_q, prev_q;

  wire         take      = hsel & hready & htrans[1];
  wire         wr_now    = wr_q;
  wire         wr_ctrl   = wr_now & (addr_q == `OFS_CONTROL_STATUS);
  wire         wr_load   = wr_now & (addr_q == `OFS_LOAD_VALUE);
  wire         wr_cmp    = wr_now & (addr_q == `OFS_COMPARE_VALUE);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_q <= 8'h00;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
    end else begin
      addr_q <= take ? haddr[7:0] : addr_q;
      wr_q   <= take & hwrite;
      rd_q   <= take & ~hwrite;
    end
  end

  // zero wait states: every transfer ends after one data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // =====================================================
  // control fields
  wire       enable    = ctrl_q[`BIT_TIMER_ENABLE];
  wire       pol       = ctrl_q[`BIT_POLARITY];
  wire       reload_on_match       = ctrl_q[`BIT_RELOAD_ON_MATCH];
  wire       ext_pin   = ctrl_q[`BIT_EXT_CLK_PIN];
  wire [3:0] mode      = ctrl_q[`MSB_MODE_SELECT:`LSB_MODE_SELECT];
  wire       m_toggle  = (mode == MODE_TOGGLE);
  wire       m_event   = (mode == MODE_EVENT);
  wire       m_width   = (mode == MODE_WIDTH);
  wire       m_period  = (mode == MODE_PERIOD);
  wire       m_capture = (mode == MODE_CAPTURE);
  // modes 0 and 1 count like toggle but never drive the pin
  wire       m_timed   = (mode == MODE_GPIO) | (mode == MODE_PULSE) | m_toggle;

  // =====================================================
  // pin synchroniser and edge strobes
  // s1_q may go metastable, so only s2_q feeds any logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      s1_q   <= timer_io_pin_i;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  wire rise      = s2_q & ~prev_q;
  wire fall      = ~s2_q & prev_q;
  wire sel_edge  = pol ? fall : rise;
  wire opp_edge  = pol ? rise : fall;

  // =====================================================
  // timer clock: internal every cycle, event mode from pin or prescaler
  wire tick      = m_event ? (ext_pin ? sel_edge : prescale_tick) : 1'b1;
  wire [W:0] inc = {1'b0, cnt_q} + {{W{1'b0}}, 1'b1};
  // carry out of the increment marks overflow
  wire wrap      = inc[W];
  wire match     = (cnt_q == cmp_q);
  // enable rising edge clears the counter before the first load
  wire start     = enable & ~en_q;

  // counting state machine for all modes
  logic set_cf;
  logic set_ovf;
  always_comb begin
    cnt_d   = cnt_q;
    first_d = first_q;
    ms_d    = ms_q;
    pin_d   = pin_q;
    cap_d   = cap_q;
    set_cf  = 1'b0;
    set_ovf = 1'b0;
    if (!enable) begin
      ms_d    = MS_WAIT;
      first_d = 1'b0;
    end else if (start) begin
      cnt_d   = `RST_WORD;
      first_d = 1'b1;
      pin_d   = pol;
      ms_d    = m_capture ? MS_RUN : MS_WAIT;
    end else if (m_timed | m_event) begin
      if (tick) begin
        if (first_q | (match & reload_on_match)) begin
          cnt_d   = load_q;
          first_d = 1'b0;
        end else begin
          cnt_d   = inc[W-1:0];
          set_ovf = wrap;
        end
      end
      // flag on the tick that makes the count equal, not one tick later
      if (tick & (cnt_d == cmp_q)) begin
        set_cf = 1'b1;
        pin_d  = m_toggle ? ~pin_q : pin_q;
      end
    end else begin
      case (ms_q)
        MS_WAIT: begin
          if (sel_edge) begin
            cnt_d = load_q;
            ms_d  = MS_RUN;
          end
        end
        MS_RUN: begin
          cnt_d   = inc[W-1:0];
          set_ovf = wrap;
          if (m_width & opp_edge) begin
            set_cf = 1'b1;
            cap_d  = cnt_q;
            ms_d   = reload_on_match ? MS_WAIT : MS_HALT;
            cnt_d  = cnt_q;
          end else if ((m_period | m_capture) & sel_edge) begin
            set_cf = 1'b1;
            cap_d  = cnt_q;
            if (m_capture) begin
              ms_d  = MS_HALT;
              cnt_d = cnt_q;
            end else if (reload_on_match) begin
              cnt_d = load_q;
            end
          end
        end
        MS_HALT: begin
          // after width end with reload off: free count, wait for start
          if (m_width) begin
            cnt_d   = inc[W-1:0];
            set_ovf = wrap;
            if (sel_edge) begin
              cnt_d = load_q;
              ms_d  = MS_RUN;
            end
          end
        end
        default: ms_d = MS_WAIT;
      endcase
    end
  end

  // =====================================================
  // flags: hardware set wins over software write-one clear
  wire clr_ovf = wr_ctrl & hwdata[`BIT_OVERFLOW_FLAG];
  wire clr_cf  = wr_ctrl & hwdata[`BIT_COMPARE_FLAG];
  assign ovf_d = set_ovf | (ovf_q & ~clr_ovf);
  assign cf_d  = set_cf | (cf_q & ~clr_cf);
  // interrupt-service clear is not modelled; software writes one

  assign ctrl_d = wr_ctrl ? {hwdata[W-1:0] & 24'h00_82FF} : ctrl_q;

  // =====================================================
  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `RST_CONTROL;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      load_q <= `RST_WORD;
    end else begin
      load_q <= wr_load ? hwdata[W-1:0] : load_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmp_q <= `RST_WORD;
    end else begin
      cmp_q <= wr_cmp ? hwdata[W-1:0] : cmp_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cap_q <= `RST_WORD;
    end else begin
      cap_q <= cap_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= `RST_WORD;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cf_q <= 1'b0;
    end else begin
      cf_q <= cf_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= enable;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_q <= 1'b0;
    end else begin
      first_q <= first_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ms_q <= MS_WAIT;
    end else begin
      ms_q <= ms_d;
    end
  end

  // =====================================================
  // outputs
  assign timer_io_pin_o  = pin_q;
  assign timer_io_pin_oe = m_toggle & enable;
  assign compare_irq     = cf_q & ctrl_q[`BIT_CMP_IRQ_EN];
  assign overflow_irq    = ovf_q & ctrl_q[`BIT_OVF_IRQ_EN];

  wire [W-1:0] status_word = ctrl_q
                           | ({{(W-1){1'b0}}, ovf_q} << `BIT_OVERFLOW_FLAG)
                           | ({{(W-1){1'b0}}, cf_q} << `BIT_COMPARE_FLAG);
  wire hit_ctrl = (addr_q == `OFS_CONTROL_STATUS);
  wire hit_cmp  = (addr_q == `OFS_COMPARE_VALUE);
  wire hit_cap  = (addr_q == `OFS_COUNT_READBACK);
  wire hit_cnt  = (addr_q == `OFS_COUNTER);
  wire [W-1:0] rd_word = hit_ctrl ? status_word :
                         hit_cmp  ? cmp_q :
                         hit_cap  ? cap_q :
                         hit_cnt  ? cnt_q : `RST_WORD;
  // read data is zero outside a read data phase
  assign hrdata = rd_q ? {8'h00, rd_word} : 32'h0000_0000;

endmodule
`default_nettype wire

// file: timer_chan_checker.sv
`timescale 1ns/1ps
`default_nettype none
module timer_chan_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // pin and interrupts
  input wire logic        timer_io_pin_o,
  input wire logic        timer_io_pin_oe,
  input wire logic        compare_irq,
  input wire logic        overflow_irq
);
  // ====
  // control shadow, rebuilt from bus writes
  logic        dph_q;
  logic        wr_q;
  logic [7:0]  ofs_q;
  logic [15:0] ctl_q;
  wire logic   en2;
  assign en2 = ctl_q[0] && ctl_q[7:4] == 4'h2;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dph_q <= 1'b0;
      wr_q  <= 1'b0;
      ofs_q <= 8'h00;
      ctl_q <= 16'h0000;
    end else begin
      dph_q <= hsel && hready && htrans[1];
      wr_q  <= hwrite;
      ofs_q <= haddr[7:0];
      if (dph_q && wr_q && ofs_q == 8'h00) ctl_q <= hwdata[15:0];
    end
  end
  // ====
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_rd_idle; !dph_q |-> hrdata == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
  property p_rd_top; hrdata[31:24] == 8'h00; endproperty
  a_rd_top: assert property (p_rd_top) else $error("read data top byte set");
  property p_rd_ctl;
    dph_q && !wr_q && ofs_q == 8'h00 |-> (hrdata[15:0] & 16'h82FF) == (ctl_q & 16'h82FF);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control read differs");
  property p_oe; timer_io_pin_oe == en2; endproperty
  a_oe: assert property (p_oe) else $error("pin drive wrong");
  property p_pin_init; $rose(en2) |-> ##[0:1] timer_io_pin_o == ctl_q[3]; endproperty
  a_pin_init: assert property (p_pin_init) else $error("pin start level wrong");
  property p_pin_chg;
    $past(en2, 2) && $past(en2) && en2 && ctl_q[2] && $changed(timer_io_pin_o)
      |-> ##[0:1] compare_irq;
  endproperty
  a_pin_chg: assert property (p_pin_chg) else $error("toggle without compare");
  property p_cmp_irq; compare_irq |-> ctl_q[2]; endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("compare irq unmasked");
  property p_ovf_irq; overflow_irq |-> ctl_q[1]; endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq unmasked");
  c_tog: cover property (en2 && $changed(timer_io_pin_o));
  c_cmp: cover property (compare_irq);
  c_rd: cover property (dph_q && !wr_q && ofs_q == 8'h0C);
endmodule
bind timer_chan timer_chan_checker u_chk (.*);
`default_nettype wire

// file: timer_chan_defs.svh
`ifndef TIMER_CHAN_DEFS_SVH
`define TIMER_CHAN_DEFS_SVH

// =====================================================
// register byte offsets
`define OFS_CONTROL_STATUS 8'h00
`define OFS_LOAD_VALUE     8'h04
`define OFS_COMPARE_VALUE  8'h08
`define OFS_COUNT_READBACK 8'h0C
`define OFS_COUNTER        8'h10

// =====================================================
// control_status field positions
`define BIT_TIMER_ENABLE   0
`define BIT_OVF_IRQ_EN     1
`define BIT_CMP_IRQ_EN     2
`define BIT_POLARITY       3
`define MSB_MODE_SELECT    7
`define LSB_MODE_SELECT    4
`define BIT_RELOAD_ON_MATCH 9
`define BIT_EXT_CLK_PIN    15
`define BIT_OVERFLOW_FLAG  20
`define BIT_COMPARE_FLAG   21

// =====================================================
// reset values and counter maximum
`define RST_CONTROL        24'h00_0000
`define RST_WORD           24'h00_0000
`define CNT_MAX            24'hFF_FFFF

`endif

// file: timer_chan_pkg.sv
package timer_chan_pkg;
  typedef enum logic [3:0] {
    MODE_GPIO    = 4'b0000,
    MODE_PULSE   = 4'b0001,
    MODE_TOGGLE  = 4'b0010,
    MODE_EVENT   = 4'b0011,
    MODE_WIDTH   = 4'b0100,
    MODE_PERIOD  = 4'b0101,
    MODE_CAPTURE = 4'b0110
  } mode_t;

  typedef enum logic [1:0] {
    MS_WAIT  = 2'b00,
    MS_RUN   = 2'b01,
    MS_HALT  = 2'b10
  } meas_t;
endpackage

// file: timer_chan_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timer_chan_tb_top;
  logic        clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tick = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, q, r, rb;
  wire logic   hrdy, hresp, pin_o, pin_oe, pin_i, cirq, oirq;
  wire logic [31:0] hrdata;
  int          err_total = 0, num_checks = 0, t;
  logic [31:0] mctl [3] = '{32'h0000_0245, 32'h0000_0055, 32'h0000_006D};
  logic [31:0] ectl [3] = '{32'h0000_8035, 32'h0000_803D, 32'h0000_0035};
  logic [7:0]  ofs [4] = '{8'h00, 8'h0C, 8'h10, 8'h14};
  timer_chan dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .prescale_tick(tick),
    .timer_io_pin_i(pin_i), .timer_io_pin_o(pin_o), .timer_io_pin_oe(pin_oe),
    .compare_irq(cirq), .overflow_irq(oirq));
  pin_source src (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));
  initial forever #5 clk = ~clk;
  // ====
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  task automatic off;
    bus(1'b1, 8'h00, '0);
    bus(1'b1, 8'h00, 32'h0020_0000);
    cyc(1);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cnt(input int n);
    logic l;
    l = pin_o;
    t = 0;
    repeat (n) begin
      @(posedge clk);
      if (pin_o !== l) t++;
      l = pin_o;
    end
  endtask
  task automatic ev(input int i, input int n);
    repeat (n) begin
      if (i == 2) begin
        cyc(3);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
      end else begin
        src.drive(i == 0, 3);
        src.drive(i == 1, 3);
      end
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ====
  // tests
  initial begin
    cyc(20000);
    err_total++;
    stop_test;
  end
  initial begin
    cyc(3);
    resetn <= 1'b1;
    cyc(1);
    bus(1'b1, 8'h14, '1);
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], '0);
      chk("reset", '0, q);
    end
    $display("test reset done");
    bus(1'b1, 8'h04, '0);
    bus(1'b1, 8'h08, 32'h0000_0003);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 8'h00, i ? 32'h0000_002D : 32'h0000_0225);
      cyc(2);
      chk("pin start", i, pin_o);
      cnt(40);
      chk("toggles", 1, i ? t == 1 : t inside {[9:11]});
      chk("cmp irq", 1, cirq);
      bus(1'b0, 8'h00, '0);
      chk("flag", 1, q[21]);
      off;
      chk("cleared", '0, {cirq, pin_oe});
    end
    $display("test toggle done");
    bus(1'b1, 8'h04, 32'h0000_0010);
    bus(1'b1, 8'h08, 32'h0000_0014);
    for (int i = 0; i < 3; i++) begin
      src.drive(i == 1, 6);
      bus(1'b1, 8'h00, ectl[i]);
      ev(i, 3);
      bus(1'b0, 8'h10, '0);
      chk("events", 32'h0000_0012, q);
      chk("early", 0, cirq);
      ev(i, 2);
      cyc(1);
      chk("match", 1, cirq);
      off;
    end
    $display("test event done");
    bus(1'b1, 8'h04, 32'h0000_0100);
    for (int i = 0; i < 3; i++) begin
      src.drive(1'b0, 6);
      bus(1'b1, 8'h00, mctl[i]);
      src.drive(1'b1, 20);
      chk("no end", 0, cirq);
      src.drive(1'b0, 10);
      if (i == 1) src.drive(1'b1, 6);
      chk("end", 1, cirq);
      bus(1'b0, 8'h0C, '0);
      rb = q;
      chk("measure", 1, i == 2 || rb - 32'h0000_0114 - 11 * i <= 2);
      bus(1'b0, 8'h10, '0);
      r = q;
      cyc(4);
      bus(1'b0, 8'h10, '0);
      chk("halt", i != 1, q == r);
      chk("held", 1, i != 2 || r == rb);
      off;
    end
    $display("test measure done");
    bus(1'b1, 8'h04, 32'h00FF_FFF0);
    bus(1'b1, 8'h00, 32'h0000_0003);
    cyc(30);
    chk("ovf irq", 1, oirq);
    off;
    bus(1'b1, 8'h00, 32'h0010_0000);
    bus(1'b0, 8'h00, '0);
    chk("ovf flag", 0, q[20]);
    $display("test overflow done");
    stop_test;
  end
endmodule
`default_nettype wire
